// ### rtcu_pkg.sv
// Package with register map, field positions and timing constants of the RTC update sequencer.
package rtcu_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_SEC   = 6'h00;
  localparam logic [5:0] IDX_ASEC  = 6'h01;
  localparam logic [5:0] IDX_MIN   = 6'h02;
  localparam logic [5:0] IDX_AMIN  = 6'h03;
  localparam logic [5:0] IDX_HOUR  = 6'h04;
  localparam logic [5:0] IDX_AHOUR = 6'h05;
  localparam logic [5:0] IDX_DOW   = 6'h06;
  localparam logic [5:0] IDX_DOM   = 6'h07;
  localparam logic [5:0] IDX_MON   = 6'h08;
  localparam logic [5:0] IDX_YEAR  = 6'h09;
  localparam logic [5:0] IDX_CTLA  = 6'h0a;
  localparam logic [5:0] IDX_CTLB  = 6'h0b;
  localparam logic [5:0] IDX_STAC  = 6'h0c;
  localparam logic [5:0] IDX_STAD  = 6'h0d;
  localparam int         NUM_TIME  = 10;
  localparam int         ADDR_LSB  = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int A_PEND_BIT     = 7;
  localparam int A_DIV_LSB      = 4;
  localparam int A_DIV_MSB      = 6;
  localparam int B_SET_BIT      = 7;
  localparam int B_ALARM_IE_BIT = 5;
  localparam int B_DONE_IE_BIT  = 4;
  localparam int C_IRQ_BIT      = 7;
  localparam int C_ALARM_BIT    = 5;
  localparam int C_DONE_BIT     = 4;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [6:0] CTLA_RST   = 7'h20;
  localparam logic [7:0] CTLB_RST   = 8'h00;
  localparam logic [7:0] STAD_VALUE = 8'h80;
  localparam logic [1:0] ALARM_ANY  = 2'h3;
  localparam logic [7:0] SEC_LAST   = 8'h3b;
  localparam logic [7:0] HOUR_LAST  = 8'h17;
  localparam logic [7:0] DOW_LAST   = 8'h07;
  localparam logic [7:0] MON_LAST   = 8'h0c;
  localparam logic [7:0] YEAR_LAST  = 8'h63;
  localparam logic [7:0] FIRST_DAY  = 8'h01;
  localparam logic [7:0] TIME_RST   = 8'h00;
  localparam logic [7:0] DATE_RST   = 8'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 100;
  localparam int SECOND_S    = 1;
  localparam int WARN_US     = 244;
  localparam int UPDATE_MS   = 2;
  localparam int SECOND_CYC  = SECOND_S * 1000000 * CLK_MHZ;
  localparam int WARN_CYC    = WARN_US * CLK_MHZ;
  localparam int UPDATE_CYC  = UPDATE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W       = 27;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WARN = 3'b010,
    ST_ACT  = 3'b100
  } rtcu_state_e;

endpackage

// ### rtcu_update_ctrl.sv
// RTC update-cycle sequencer with time/date, alarm and control/status registers on APB.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module rtcu_update_ctrl
  import rtcu_pkg::*;
#(
  parameter int unsigned SEC_CYC  = SECOND_CYC,
  parameter int unsigned WARN_LEN = WARN_CYC,
  parameter int unsigned UPD_LEN  = UPDATE_CYC
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             update_pending_flag,
  output logic             irq_req
);

  // ----------------------------------------------------------------
  // Cycle counts of the three phases of one second
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(SEC_CYC - WARN_LEN - UPD_LEN - 1);
  localparam logic [CNT_W-1:0] WARN_LAST = CNT_W'(WARN_LEN - 1);
  localparam logic [CNT_W-1:0] UPD_LAST  = CNT_W'(UPD_LEN - 1);

  rtcu_state_e      st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0]       tm_q [NUM_TIME];
  logic [7:0]       tm_d [NUM_TIME];
  logic [6:0]       ctla_q, ctla_d;
  logic [7:0]       ctlb_q, ctlb_d;
  logic             done_flag_q, done_flag_d;
  logic             alarm_flag_q, alarm_flag_d;
  logic             irq_q, irq_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             err_q, err_d;
  logic             cap_q, cap_d;

  logic             run;
  logic             advance;
  logic             done;
  logic             busy;
  logic             match;
  logic [5:0]       idx;
  logic             mapped;
  logic             finish;
  logic             wr_en;
  logic             rd_stac;
  logic [7:0]       mon_days;
  logic             irq_sum;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Read data and the error flag are taken in the setup cycle, so no access waits while ce is high.
  assign idx     = paddr[7:ADDR_LSB];
  assign mapped  = (paddr[ADDR_LSB-1:0] == 2'h0) && (idx <= IDX_STAD);
  assign pready  = penable & ce & cap_q;
  assign finish  = psel & penable & pready;
  assign wr_en   = finish & pwrite & mapped;
  assign rd_stac = finish & ~pwrite & (idx == IDX_STAC) & mapped;
  assign busy    = (st_q == ST_ACT);
  assign prdata  = prdata_q;
  assign pslverr = err_q & pready;

  // ----------------------------------------------------------------
  // Update sequencer
  // ----------------------------------------------------------------
  // Clearing the divider or setting the inhibit bit aborts a running update at the next edge.
  assign run = (ctla_q[A_DIV_MSB:A_DIV_LSB] != 3'h0) && !ctlb_q[B_SET_BIT];

  // The sequencer idles, then warns for the pending time, then runs the active period.
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q + CNT_W'(1);
    advance = 1'b0;
    done    = 1'b0;
    if (!run) begin
      st_d  = ST_IDLE;
      cnt_d = '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (cnt_q == IDLE_LAST) begin
            st_d  = ST_WARN;
            cnt_d = '0;
          end
        end
        ST_WARN: begin
          if (cnt_q == WARN_LAST) begin
            st_d  = ST_ACT;
            cnt_d = '0;
          end
        end
        ST_ACT: begin
          // Time moves on the first active cycle; the registers stay blocked until the end.
          advance = (cnt_q == '0);
          if (cnt_q == UPD_LAST) begin
            st_d  = ST_IDLE;
            cnt_d = '0;
            done  = 1'b1;
          end
        end
        default: begin
          st_d  = ST_IDLE;
          cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q  <= ST_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign update_pending_flag = (st_q != ST_IDLE);

  // ----------------------------------------------------------------
  // Time and date registers
  // ----------------------------------------------------------------
  // Binary 24-hour calendar; every year divisible by four is taken as a leap year.
  always_comb begin
    case (tm_q[IDX_MON[3:0]])
      8'h02:   mon_days = (tm_q[IDX_YEAR[3:0]][1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04:   mon_days = 8'h1e;
      8'h06:   mon_days = 8'h1e;
      8'h09:   mon_days = 8'h1e;
      8'h0b:   mon_days = 8'h1e;
      default: mon_days = 8'h1f;
    endcase
  end

  function automatic logic hit(input logic [7:0] now, input logic [7:0] alarm);
    hit = (alarm[7:6] == ALARM_ANY) || (now == alarm);
  endfunction

  // An alarm byte with both top bits set matches any value.
  assign match = hit(tm_q[IDX_SEC[3:0]], tm_q[IDX_ASEC[3:0]]) &&
                 hit(tm_q[IDX_MIN[3:0]], tm_q[IDX_AMIN[3:0]]) &&
                 hit(tm_q[IDX_HOUR[3:0]], tm_q[IDX_AHOUR[3:0]]);

  always_comb begin
    logic carry;
    carry = 1'b0;
    for (int i = 0; i < NUM_TIME; i++) begin
      tm_d[i] = tm_q[i];
    end
    if (advance) begin
      carry = 1'b1;
      if (tm_q[IDX_SEC[3:0]] == SEC_LAST) begin
        tm_d[IDX_SEC[3:0]] = TIME_RST;
      end else begin
        tm_d[IDX_SEC[3:0]] = tm_q[IDX_SEC[3:0]] + 8'h01;
        carry = 1'b0;
      end
      if (carry) begin
        if (tm_q[IDX_MIN[3:0]] == SEC_LAST) begin
          tm_d[IDX_MIN[3:0]] = TIME_RST;
        end else begin
          tm_d[IDX_MIN[3:0]] = tm_q[IDX_MIN[3:0]] + 8'h01;
          carry = 1'b0;
        end
      end
      if (carry) begin
        if (tm_q[IDX_HOUR[3:0]] == HOUR_LAST) begin
          tm_d[IDX_HOUR[3:0]] = TIME_RST;
          tm_d[IDX_DOW[3:0]]  = (tm_q[IDX_DOW[3:0]] == DOW_LAST) ? FIRST_DAY : tm_q[IDX_DOW[3:0]] + 8'h01;
        end else begin
          tm_d[IDX_HOUR[3:0]] = tm_q[IDX_HOUR[3:0]] + 8'h01;
          carry = 1'b0;
        end
      end
      if (carry) begin
        if (tm_q[IDX_DOM[3:0]] >= mon_days) begin
          tm_d[IDX_DOM[3:0]] = FIRST_DAY;
        end else begin
          tm_d[IDX_DOM[3:0]] = tm_q[IDX_DOM[3:0]] + 8'h01;
          carry = 1'b0;
        end
      end
      if (carry) begin
        if (tm_q[IDX_MON[3:0]] == MON_LAST) begin
          tm_d[IDX_MON[3:0]] = FIRST_DAY;
        end else begin
          tm_d[IDX_MON[3:0]] = tm_q[IDX_MON[3:0]] + 8'h01;
          carry = 1'b0;
        end
      end
      if (carry) begin
        tm_d[IDX_YEAR[3:0]] = (tm_q[IDX_YEAR[3:0]] == YEAR_LAST) ? TIME_RST : tm_q[IDX_YEAR[3:0]] + 8'h01;
      end
    end else if (wr_en && (idx < 6'(NUM_TIME)) && !busy) begin
      // A write that lands while the update runs is dropped rather than stalled.
      tm_d[idx[3:0]] = pwdata[7:0];
    end
  end

  // Day of month and month start at one; every other time register starts at zero.
  generate
    for (genvar g = 0; g < NUM_TIME; g++) begin : g_time
      localparam logic [7:0] RST_VAL = (g >= int'(IDX_DOM)) && (g <= int'(IDX_MON)) ? DATE_RST : TIME_RST;
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          tm_q[g] <= RST_VAL;
        end else if (ce) begin
          tm_q[g] <= tm_d[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  always_comb begin
    ctla_d       = ctla_q;
    ctlb_d       = ctlb_q;
    done_flag_d  = done_flag_q;
    alarm_flag_d = alarm_flag_q;
    if (wr_en && (idx == IDX_CTLA)) begin
      ctla_d = pwdata[6:0];
    end
    if (wr_en && (idx == IDX_CTLB)) begin
      ctlb_d = pwdata[7:0];
      // Setting the inhibit bit also clears the update interrupt enable.
      if (pwdata[B_SET_BIT]) begin
        ctlb_d[B_DONE_IE_BIT] = 1'b0;
      end
    end
    // A read of the third status register clears its flags; a same-cycle event still sets them.
    if (rd_stac) begin
      done_flag_d  = 1'b0;
      alarm_flag_d = 1'b0;
    end
    if (done) begin
      done_flag_d = 1'b1;
      if (match) begin
        alarm_flag_d = 1'b1;
      end
    end
    // The request is registered so that it changes on the same edge as the flags.
    irq_d = (done_flag_d & ctlb_d[B_DONE_IE_BIT]) | (alarm_flag_d & ctlb_d[B_ALARM_IE_BIT]);
  end

  // Summary bit of the third status register, taken from the stored flags.
  assign irq_sum = (done_flag_q & ctlb_q[B_DONE_IE_BIT]) | (alarm_flag_q & ctlb_q[B_ALARM_IE_BIT]);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctla_q       <= CTLA_RST;
      ctlb_q       <= CTLB_RST;
      done_flag_q  <= 1'b0;
      alarm_flag_q <= 1'b0;
      irq_q        <= 1'b0;
    end else if (ce) begin
      ctla_q       <= ctla_d;
      ctlb_q       <= ctlb_d;
      done_flag_q  <= done_flag_d;
      alarm_flag_q <= alarm_flag_d;
      irq_q        <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  assign irq_req = irq_q;

  // ----------------------------------------------------------------
  // Read data capture
  // ----------------------------------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    err_d    = err_q;
    cap_d    = psel & ~finish;
    if (psel && !cap_q) begin
      prdata_d = '0;
      err_d    = ~mapped;
      if (!pwrite && mapped) begin
        if (idx < 6'(NUM_TIME)) begin
          // A blocked read returns zero and still completes without wait states.
          prdata_d[7:0] = busy ? 8'h00 : tm_q[idx[3:0]];
        end else begin
          case (idx)
            IDX_CTLA: prdata_d[7:0] = {update_pending_flag, ctla_q};
            IDX_CTLB: prdata_d[7:0] = ctlb_q;
            IDX_STAC: begin
              prdata_d[C_IRQ_BIT]   = irq_sum;
              prdata_d[C_ALARM_BIT] = alarm_flag_q;
              prdata_d[C_DONE_BIT]  = done_flag_q;
            end
            IDX_STAD: prdata_d[7:0] = STAD_VALUE;
            default:  prdata_d[7:0] = 8'h00;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= '0;
      err_q    <= 1'b0;
      cap_q    <= 1'b0;
    end else if (ce) begin
      prdata_q <= prdata_d;
      err_q    <= err_d;
      cap_q    <= cap_d;
    end
  end

endmodule

// ### rtcu_update_ctrl_props.sv
// Checker of the RTC update sequencer port behaviour.
`timescale 1ns/1ps
module rtcu_update_ctrl_chk #(
  parameter int unsigned SEC_CYC  = 400,
  parameter int unsigned WARN_LEN = 20,
  parameter int unsigned UPD_LEN  = 50
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        update_pending_flag,
  input wire logic        irq_req
);
  // ----------------------------------------------------------------
  // Phase length counters
  // ----------------------------------------------------------------
  logic [31:0] pcnt_q;
  logic [31:0] pcnt_d;
  logic [31:0] lcnt_q;
  logic [31:0] lcnt_d;
  logic        armed_q;
  logic        armed_d;
  logic        pend_q;
  wire         acc   = psel && penable && pready;
  wire         wr    = acc && pwrite;
  wire         rd_c  = acc && !pwrite && paddr[7:2] == 6'h0c;
  wire         wr_stop = wr && ((paddr[7:2] == 6'h0a && pwdata[6:4] == 3'h0) || (paddr[7:2] == 6'h0b && pwdata[7]));
  always_comb begin
    pcnt_d  = update_pending_flag ? pcnt_q + {31'h0, ce} : 32'h0;
    lcnt_d  = update_pending_flag ? 32'h0 : lcnt_q + {31'h0, ce};
    armed_d = wr_stop ? 1'b0 : ((pend_q && !update_pending_flag) ? 1'b1 : armed_q);
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pcnt_q  <= 32'h0;
      lcnt_q  <= 32'h0;
      armed_q <= 1'b0;
      pend_q  <= 1'b0;
    end else begin
      pcnt_q  <= pcnt_d;
      lcnt_q  <= lcnt_d;
      armed_q <= armed_d;
      pend_q  <= update_pending_flag;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_ready_first: assert property ((psel && !penable && ce) ##1 (penable && ce) |-> pready)
    else $error("pready missing in first access cycle");
  chk_ready_gate: assert property (!(penable && ce) |-> !pready)
    else $error("pready outside access phase");
  chk_err_unmap: assert property (pready && (paddr[7:2] > 6'h0d || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not flagged");
  chk_ctl_okay: assert property (pready && paddr[7:2] >= 6'h0a && paddr[7:2] <= 6'h0d && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("control access refused");
  chk_pend_len: assert property ($fell(update_pending_flag) |-> pcnt_q == WARN_LEN + UPD_LEN)
    else $error("pending flag length wrong");
  chk_idle_len: assert property ($rose(update_pending_flag) && armed_q |-> lcnt_q == SEC_CYC - WARN_LEN - UPD_LEN)
    else $error("update period wrong");
  chk_irq_rise: assert property ($rose(irq_req) |-> $fell(update_pending_flag) || $past(wr) || $past(wr, 2))
    else $error("irq raised without cause");
  chk_irq_fall: assert property ($fell(irq_req) |-> $past(rd_c) || $past(rd_c, 2) || $past(wr) || $past(wr, 2))
    else $error("irq dropped without cause");
endmodule
bind rtcu_update_ctrl rtcu_update_ctrl_chk #(.SEC_CYC(SEC_CYC), .WARN_LEN(WARN_LEN), .UPD_LEN(UPD_LEN)) chk_i (
  .clock(clock), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .update_pending_flag(update_pending_flag),
  .irq_req(irq_req));

// ### rtcu_host.sv
// APB host model that issues register transfers to the RTC update sequencer.
`timescale 1ns/1ps
module rtcu_host (
  input  wire logic        clock,
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [7:0]       paddr   = 8'h00,
  output logic [31:0]      pwdata  = 32'h0,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads status C once and discards it, then polls until update-done shows.
  task automatic wait_done(output logic [31:0] r);
    logic e;
    xfer(1'b0, 8'h30, 8'h00, r, e);
    do xfer(1'b0, 8'h30, 8'h00, r, e); while (r[4] !== 1'b1);
  endtask
endmodule

// ### rtcu_update_ctrl_tb.sv
// Self-checking testbench of the RTC update sequencer.
`timescale 1ns/1ps
module rtcu_update_ctrl_tb;
  import rtcu_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic err;} rtcu_row_s;
  logic        clock = 1'b0;
  logic        rstn  = 1'b0;
  logic        ce    = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, update_pending_flag, irq_req, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors = 0;
  int          compares = 0;
  int          hi;
  rtcu_row_s   rows [13] = '{'{0, 8'h00, 8'h00, 8'h00, 0}, '{0, 8'h1c, 8'h00, 8'h01, 0},
    '{0, 8'h20, 8'h00, 8'h01, 0}, '{0, 8'h28, 8'h00, 8'h20, 0}, '{0, 8'h2c, 8'h00, 8'h00, 0},
    '{0, 8'h30, 8'h00, 8'h00, 0}, '{0, 8'h34, 8'h00, 8'h80, 0}, '{0, 8'h38, 8'h00, 8'h00, 1},
    '{0, 8'h29, 8'h00, 8'h00, 1}, '{1, 8'h04, 8'h01, 8'h00, 0}, '{0, 8'h04, 8'h00, 8'h01, 0},
    '{1, 8'h0c, 8'hc0, 8'h00, 0}, '{1, 8'h14, 8'hc0, 8'h00, 0}};
  always #5 clock = ~clock;
  rtcu_update_ctrl #(.SEC_CYC(400), .WARN_LEN(20), .UPD_LEN(50)) rtcu_update_ctrl_i (
    .clock(clock), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .update_pending_flag(update_pending_flag), .irq_req(irq_req));
  rtcu_host rtcu_host_i (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wait_pend(input logic v);
    hi = 0;
    while (update_pending_flag !== v && hi < 500) begin
      @(posedge clock);
      hi++;
    end
  endtask
  task automatic complete_run();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      rtcu_host_i.xfer(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk(er === rows[i].err && (rows[i].w || rd === {24'h0, rows[i].e}), "table row");
    end
    $display("table done");
    rtcu_host_i.xfer(1'b1, 8'h2c, 8'h30, rd, er);
    wait_pend(1'b1);
    chk(update_pending_flag === 1'b1, "no update warning");
    rtcu_host_i.xfer(1'b0, 8'h28, 8'h00, rd, er);
    chk(rd[7] === 1'b1, "pending bit not set");
    repeat (20) @(posedge clock);
    rtcu_host_i.xfer(1'b1, 8'h00, 8'h2a, rd, er);
    rtcu_host_i.xfer(1'b0, 8'h00, 8'h00, rd, er);
    chk(rd === 32'h0 && er === 1'b0, "blocked read");
    rtcu_host_i.xfer(1'b0, 8'h2c, 8'h00, rd, er);
    chk(rd === 32'h30 && er === 1'b0, "control read in update");
    wait_pend(1'b0);
    chk(update_pending_flag === 1'b0 && irq_req === 1'b1, "update end");
    rtcu_host_i.xfer(1'b0, 8'h00, 8'h00, rd, er);
    chk(rd === 32'h01, "second not advanced or write kept");
    rtcu_host_i.xfer(1'b0, 8'h30, 8'h00, rd, er);
    chk(rd === 32'hb0, "status flags");
    rtcu_host_i.xfer(1'b0, 8'h30, 8'h00, rd, er);
    chk(rd === 32'h0 && irq_req === 1'b0, "read clear");
    $display("update test done");
    rtcu_host_i.xfer(1'b0, 8'h28, 8'h00, rd, er);
    chk(rd[7] === 1'b0, "pending before time access");
    rtcu_host_i.xfer(1'b1, 8'h2c, 8'h00, rd, er);
    rtcu_host_i.xfer(1'b1, 8'h04, 8'h02, rd, er);
    rtcu_host_i.wait_done(rd);
    chk(rd === 32'h30 && irq_req === 1'b0, "alarm without enable");
    $display("alarm test done");
    for (int k = 0; k < 2; k++) begin
      rtcu_host_i.xfer(1'b1, k ? 8'h28 : 8'h2c, k ? 8'h00 : 8'h80, rd, er);
      hi = 0;
      repeat (450) @(posedge clock) if (update_pending_flag !== 1'b0) hi++;
      chk(hi == 0, "update while stopped");
      rtcu_host_i.xfer(1'b1, k ? 8'h28 : 8'h2c, k ? 8'h20 : 8'h00, rd, er);
    end
    wait_pend(1'b1);
    chk(update_pending_flag === 1'b1, "no restart");
    $display("inhibit test done");
    ce <= 1'b0;
    hi = 0;
    repeat (450) @(posedge clock) if (update_pending_flag !== 1'b1) hi++;
    chk(hi == 0, "sequencer moved with clock enable low");
    ce   <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    chk(update_pending_flag === 1'b0 && irq_req === 1'b0 && pready === 1'b0 && prdata === 32'h0, "reset values");
    rstn <= 1'b1;
    rtcu_host_i.xfer(1'b0, 8'h28, 8'h00, rd, er);
    chk(rd === 32'h20 && er === 1'b0, "control after reset");
    rtcu_host_i.xfer(1'b0, 8'h00, 8'h00, rd, er);
    chk(rd === 32'h0 && er === 1'b0, "seconds after reset");
    $display("reset test done");
    complete_run();
  end
endmodule
